// >>> hdl/csw_regs.svh
// Purpose: Constants for the card status word encoder
// Assumes: Byte values per status word coding
// Notes: Bit b8 is the most significant bit of a byte
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH
`define CSW_SW1_OK 8'h90
`define CSW_SW1_PROACTIVE 8'h91
`define CSW_SW1_MEMORY 8'h92
`define CSW_SW1_BUSY 8'h93
`define CSW_SW1_REFER 8'h94
`define CSW_SW1_SECURITY 8'h98
`define CSW_SW1_DL_ERROR 8'h9E
`define CSW_SW1_LENGTH 8'h9F
`define CSW_SW1_BAD_P3 8'h67
`define CSW_SW1_BAD_P1P2 8'h6B
`define CSW_SW1_BAD_INS 8'h6D
`define CSW_SW1_BAD_CLA 8'h6E
`define CSW_SW1_TECH 8'h6F
`define CSW_SW2_NONE 8'h00
`define CSW_SW2_NO_EF 8'h00
`define CSW_SW2_OUT_OF_RANGE 8'h02
`define CSW_SW2_NOT_FOUND 8'h04
`define CSW_SW2_INCONSISTENT 8'h08
`define CSW_SW2_MEM_PROBLEM 8'h40
`define CSW_SW2_NO_CHV 8'h02
`define CSW_SW2_ACCESS 8'h04
`define CSW_SW2_CHV_STATUS 8'h08
`define CSW_SW2_INVAL_STATUS 8'h10
`define CSW_SW2_BLOCKED 8'h40
`define CSW_SW2_MAX_VALUE 8'h50
`define CSW_CLASS_BYTE 8'hA0
`define CSW_PAD_BYTE 8'hFF
`define CSW_DELETED_LAST 8'hFE
`define CSW_PAD_NIBBLE 4'hF
`define CSW_SERIAL_FID 16'h2FE2
`define CSW_SERIAL_BYTES 10
`endif

// >>> hdl/csw_pkg.sv
// Purpose: Types for the card status word encoder
// Assumes: Nothing beyond the header
// Notes: Command and condition enumerations
package csw_pkg;
   typedef enum logic [4:0] {
      CSW_CMD_SELECT, CSW_CMD_STATUS, CSW_CMD_UPD_BIN, CSW_CMD_UPD_REC,
      CSW_CMD_RD_BIN, CSW_CMD_RD_REC, CSW_CMD_SEEK, CSW_CMD_INCREASE,
      CSW_CMD_VERIFY, CSW_CMD_CHANGE, CSW_CMD_DISABLE, CSW_CMD_ENABLE,
      CSW_CMD_UNBLOCK, CSW_CMD_INVALIDATE, CSW_CMD_REHAB, CSW_CMD_RUN_ALG,
      CSW_CMD_SLEEP, CSW_CMD_GET_RESP, CSW_CMD_TERM_PROF, CSW_CMD_ENVELOPE,
      CSW_CMD_FETCH, CSW_CMD_TERM_RESP
   } csw_cmd_t;
   // Execution outcome reported by the command engine
   typedef enum logic [4:0] {
      CSW_OUT_OK, CSW_OUT_PROACTIVE, CSW_OUT_DL_ERROR, CSW_OUT_LENGTH,
      CSW_OUT_BUSY, CSW_OUT_RETRY, CSW_OUT_MEM_PROBLEM, CSW_OUT_NO_EF,
      CSW_OUT_OUT_OF_RANGE, CSW_OUT_NOT_FOUND, CSW_OUT_INCONSISTENT,
      CSW_OUT_NO_CHV, CSW_OUT_ACCESS, CSW_OUT_CHV_STATUS, CSW_OUT_INVAL_STATUS,
      CSW_OUT_BLOCKED, CSW_OUT_MAX_VALUE, CSW_OUT_TECH
   } csw_out_t;
   typedef enum logic [1:0] {
      CSW_ST_IDLE, CSW_ST_SEND_SW1, CSW_ST_SEND_SW2
   } csw_state_t;
endpackage : csw_pkg

// >>> hdl/csw_allow.sv
// Purpose: Per command table of permitted status conditions
// Assumes: Pure combinational lookup
// Notes: Index is the outcome enumeration value
`timescale 1ns/1ns
module csw_allow (
   input wire csw_pkg::csw_cmd_t cmd,
   input wire csw_pkg::csw_out_t outcome,
   output logic allowed
);
   import csw_pkg::*;
   logic [17:0] mask;
   always_comb begin
      case (cmd)
         CSW_CMD_SELECT, CSW_CMD_STATUS: mask = 18'h2024B;
         CSW_CMD_UPD_BIN, CSW_CMD_UPD_REC: mask = 18'h255E3;
         CSW_CMD_RD_BIN, CSW_CMD_RD_REC: mask = 18'h255C3;
         CSW_CMD_SEEK: mask = 18'h356EB;
         CSW_CMD_INCREASE: mask = 18'h356E9;
         CSW_CMD_VERIFY, CSW_CMD_CHANGE, CSW_CMD_DISABLE, CSW_CMD_ENABLE: mask = 18'h2B863;
         CSW_CMD_UNBLOCK, CSW_CMD_INVALIDATE: mask = 18'h2F8E3;
         CSW_CMD_REHAB: mask = 18'h250E3;
         CSW_CMD_RUN_ALG: mask = 18'h21449;
         CSW_CMD_SLEEP, CSW_CMD_GET_RESP: mask = 18'h20043;
         CSW_CMD_FETCH, CSW_CMD_TERM_RESP: mask = 18'h20063;
         CSW_CMD_TERM_PROF, CSW_CMD_ENVELOPE: mask = 18'h2007F;
         default: mask = 18'h00000;
      endcase
      allowed = mask[outcome];
   end
endmodule : csw_allow

// >>> hdl/csw_serial_fmt.sv
// Purpose: Packs serial number digits into the card serial file
// Assumes: Digits arrive as BCD, most significant first
// Notes: Unused digit positions padded with F
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_serial_fmt #(
   parameter int DIGITS = 20
) (
   input wire logic [DIGITS*4-1:0] digits,
   input wire logic [4:0] digit_count,
   input wire logic swap_nibbles,
   output logic [DIGITS*4-1:0] file_bytes
);
   logic [DIGITS*4-1:0] padded;
   always_comb begin
      for (int i = 0; i < DIGITS; i++) begin
         padded[(DIGITS-1-i)*4 +: 4] = (i < int'(digit_count)) ? digits[(DIGITS-1-i)*4 +: 4] : `CSW_PAD_NIBBLE;
      end
      for (int b = 0; b < DIGITS/2; b++) begin
         if (swap_nibbles) begin
            file_bytes[b*8 +: 8] = {padded[b*8 +: 4], padded[b*8+4 +: 4]};
         end else begin
            file_bytes[b*8 +: 8] = padded[b*8 +: 8];
         end
      end
   end
endmodule : csw_serial_fmt

// >>> hdl/csw_encoder.sv
// Purpose: Picks and sends the two byte status word of each command
// Assumes: Command header and engine outcome valid with done pulse
// Notes: Also formats file padding and card serial file content
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_encoder #(
   parameter int SERIAL_DIGITS = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_done,
   input wire logic class_ok,
   input wire logic ins_known,
   input wire csw_pkg::csw_cmd_t cmd,
   input wire logic p1p2_ok,
   input wire logic p3_ok,
   input wire logic [7:0] p3_correct,
   input wire csw_pkg::csw_out_t outcome,
   input wire logic [7:0] outcome_len,
   input wire logic card_toolkit,
   input wire logic handset_toolkit,
   input wire logic seek_type2,
   input wire logic tx_ready,
   input wire logic data_in_valid,
   input wire logic [7:0] data_in,
   input wire logic data_unassigned,
   input wire logic data_deleted,
   input wire logic data_deleted_last,
   input wire logic data_text7,
   input wire logic [7:0] deleted_value,
   input wire logic [SERIAL_DIGITS*4-1:0] serial_digits,
   input wire logic [4:0] serial_count,
   input wire logic serial_swap,
   input wire logic [3:0] serial_index,
   input wire logic file_optional,
   input wire logic [15:0] file_size,
   input wire logic item_present,
   input wire logic item_mandatory,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic tx_last,
   output logic busy,
   output logic data_out_valid,
   output logic [7:0] data_out,
   output logic [7:0] serial_byte,
   output logic file_ok,
   output logic [7:0] last_sw1,
   output logic [7:0] last_sw2
);
   import csw_pkg::*;
   csw_state_t state_reg;
   logic [7:0] sw1_reg;
   logic [7:0] sw2_reg;
   logic [7:0] sw1_next;
   logic [7:0] sw2_next;
   logic allowed;
   logic toolkit_ok;
   logic proactive_ok;
   logic pending_proactive_reg;
   logic [7:0] pending_len_reg;
   csw_out_t eff_out;
   logic [SERIAL_DIGITS*4-1:0] serial_image;

   csw_allow u_allow (
      .cmd(cmd),
      .outcome(eff_out),
      .allowed(allowed)
   );

   csw_serial_fmt #(.DIGITS(SERIAL_DIGITS)) u_serial (
      .digits(serial_digits),
      .digit_count(serial_count),
      .swap_nibbles(serial_swap),
      .file_bytes(serial_image)
   );

   // ****************************************
   // Status word selection
   // ****************************************
   // toolkit statuses need both ends
   assign toolkit_ok = card_toolkit & handset_toolkit;
   assign proactive_ok = toolkit_ok & ~(cmd == CSW_CMD_SEEK && seek_type2);

   always_comb begin
      eff_out = outcome;
      if ((outcome == CSW_OUT_PROACTIVE) && !proactive_ok) begin
         eff_out = CSW_OUT_OK;
      end
      if (((outcome == CSW_OUT_BUSY) || (outcome == CSW_OUT_DL_ERROR)) && !toolkit_ok) begin
         eff_out = CSW_OUT_TECH;
      end
   end

   always_comb begin
      sw1_next = `CSW_SW1_TECH;
      sw2_next = `CSW_SW2_NONE;
      if (!class_ok) begin
         sw1_next = `CSW_SW1_BAD_CLA;
      end else if (!ins_known) begin
         sw1_next = `CSW_SW1_BAD_INS;
      end else if (!p1p2_ok && outcome == CSW_OUT_OUT_OF_RANGE) begin
         sw1_next = `CSW_SW1_REFER;
         sw2_next = `CSW_SW2_OUT_OF_RANGE;
      end else if (!p1p2_ok) begin
         sw1_next = `CSW_SW1_BAD_P1P2;
      end else if (!p3_ok) begin
         sw1_next = `CSW_SW1_BAD_P3;
         sw2_next = p3_correct;
      end else if (!allowed) begin
         sw1_next = `CSW_SW1_TECH;
      end else begin
         case (eff_out)
            CSW_OUT_OK: begin
               if (cmd == CSW_CMD_GET_RESP && pending_proactive_reg && toolkit_ok) begin
                  sw1_next = `CSW_SW1_PROACTIVE;
                  sw2_next = pending_len_reg;
               end else begin
                  sw1_next = `CSW_SW1_OK;
               end
            end
            CSW_OUT_PROACTIVE: begin
               sw1_next = `CSW_SW1_PROACTIVE;
               sw2_next = outcome_len;
            end
            CSW_OUT_DL_ERROR: begin
               sw1_next = `CSW_SW1_DL_ERROR;
               sw2_next = outcome_len;
            end
            CSW_OUT_LENGTH: begin
               sw1_next = `CSW_SW1_LENGTH;
               sw2_next = outcome_len;
            end
            CSW_OUT_BUSY: sw1_next = `CSW_SW1_BUSY;
            CSW_OUT_RETRY: begin
               sw1_next = `CSW_SW1_MEMORY;
               sw2_next = {4'h0, outcome_len[3:0]};
            end
            CSW_OUT_MEM_PROBLEM: begin
               sw1_next = `CSW_SW1_MEMORY;
               sw2_next = `CSW_SW2_MEM_PROBLEM;
            end
            CSW_OUT_NO_EF: sw1_next = `CSW_SW1_REFER;
            CSW_OUT_OUT_OF_RANGE: begin
               sw1_next = `CSW_SW1_REFER;
               sw2_next = `CSW_SW2_OUT_OF_RANGE;
            end
            CSW_OUT_NOT_FOUND: begin
               sw1_next = `CSW_SW1_REFER;
               sw2_next = `CSW_SW2_NOT_FOUND;
            end
            CSW_OUT_INCONSISTENT: begin
               sw1_next = `CSW_SW1_REFER;
               sw2_next = `CSW_SW2_INCONSISTENT;
            end
            CSW_OUT_NO_CHV: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_NO_CHV;
            end
            CSW_OUT_ACCESS: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_ACCESS;
            end
            CSW_OUT_CHV_STATUS: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_CHV_STATUS;
            end
            CSW_OUT_INVAL_STATUS: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_INVAL_STATUS;
            end
            CSW_OUT_BLOCKED: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_BLOCKED;
            end
            CSW_OUT_MAX_VALUE: begin
               sw1_next = `CSW_SW1_SECURITY;
               sw2_next = `CSW_SW2_MAX_VALUE;
            end
            default: sw1_next = `CSW_SW1_TECH;
         endcase
      end
   end

   // ****************************************
   // Deferred proactive after type 2 seek
   // ****************************************
   // remember for response retrieval
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pending_proactive_reg <= 1'b0;
         pending_len_reg <= 8'h00;
      end else if (cmd_done && state_reg == CSW_ST_IDLE) begin
         if (cmd == CSW_CMD_SEEK && seek_type2 && outcome == CSW_OUT_PROACTIVE && toolkit_ok) begin
            pending_proactive_reg <= 1'b1;
            pending_len_reg <= outcome_len;
         end else if (cmd == CSW_CMD_GET_RESP) begin
            pending_proactive_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Captured and completed words
   // ****************************************
   // word held for both bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw1_reg <= 8'h00;
         sw2_reg <= 8'h00;
      end else if (cmd_done && state_reg == CSW_ST_IDLE) begin
         sw1_reg <= sw1_next;
         sw2_reg <= sw2_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_sw1 <= 8'h00;
         last_sw2 <= 8'h00;
      end else if (tx_ready && state_reg == CSW_ST_SEND_SW2) begin
         last_sw1 <= sw1_reg;
         last_sw2 <= sw2_reg;
      end
   end

   // ****************************************
   // Status word transmit sequence
   // ****************************************
   // first then second byte, back to back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= CSW_ST_IDLE;
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         tx_last <= 1'b0;
         busy <= 1'b0;
      end else begin
         case (state_reg)
            CSW_ST_IDLE: begin
               if (cmd_done) begin
                  tx_valid <= 1'b1;
                  tx_byte <= sw1_next;
                  tx_last <= 1'b0;
                  busy <= 1'b1;
                  state_reg <= CSW_ST_SEND_SW1;
               end
            end
            CSW_ST_SEND_SW1: begin
               if (tx_ready) begin
                  tx_byte <= sw2_reg;
                  tx_last <= 1'b1;
                  state_reg <= CSW_ST_SEND_SW2;
               end
            end
            CSW_ST_SEND_SW2: begin
               if (tx_ready) begin
                  tx_valid <= 1'b0;
                  tx_last <= 1'b0;
                  busy <= 1'b0;
                  state_reg <= CSW_ST_IDLE;
               end
            end
            default: state_reg <= CSW_ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // File data conventions
   // ****************************************
   // unassigned padding, deleted value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_out_valid <= 1'b0;
         data_out <= 8'h00;
      end else begin
         data_out_valid <= data_in_valid;
         if (data_deleted) begin
            data_out <= data_deleted_last ? deleted_value : `CSW_PAD_BYTE;
         end else if (data_unassigned) begin
            data_out <= `CSW_PAD_BYTE;
         end else if (data_text7) begin
            // b8 cleared, b8 is bit 7
            data_out <= {1'b0, data_in[6:0]};
         end else begin
            data_out <= data_in;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         file_ok <= 1'b1;
      end else if (file_size == 16'h0000) begin
         file_ok <= file_optional;
      end else begin
         file_ok <= item_present | ~item_mandatory;
      end
   end

   // ten byte serial file, twenty digits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_byte <= `CSW_PAD_BYTE;
      end else if (int'(serial_index) < `CSW_SERIAL_BYTES) begin
         serial_byte <= serial_image[(SERIAL_DIGITS/2-1-int'(serial_index))*8 +: 8];
      end else begin
         serial_byte <= `CSW_PAD_BYTE;
      end
   end
endmodule : csw_encoder

// >>> test/csw_encoder_sva.sv
// Purpose: Port checker of the status word encoder
// Assumes: One clock, rst async high
// Notes: Bound to csw_encoder after endmodule
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_encoder_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_done,
   input wire logic busy,
   input wire logic class_ok,
   input wire logic ins_known,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   input wire logic data_in_valid,
   input wire logic data_unassigned,
   input wire logic data_deleted,
   input wire logic data_deleted_last,
   input wire logic data_text7,
   input wire logic data_out_valid,
   input wire logic [7:0] data_out,
   input wire logic [3:0] serial_index,
   input wire logic [7:0] serial_byte
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_sw1_go;
      tx_valid && tx_ready && !tx_last;
   endsequence
   sequence s_sw2_go;
      tx_valid && tx_ready && tx_last;
   endsequence
   a_first_byte_next: assert property (cmd_done && !busy |=> tx_valid && busy && !tx_last)
      else $error("first status byte missing after take");
   a_class_first: assert property (cmd_done && !busy && !class_ok |=> tx_byte == `CSW_SW1_BAD_CLA)
      else $error("wrong class not answered first");
   a_ins_second: assert property (cmd_done && !busy && class_ok && !ins_known |=> tx_byte == 8'h6D)
      else $error("unknown instruction not answered");
   a_second_follows: assert property (s_sw1_go |=> tx_valid && tx_last)
      else $error("second status byte missing");
   a_byte_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
      else $error("status byte changed while stalled");
   a_generic_zero: assert property (s_sw1_go ##0 (tx_byte inside {8'h6B, 8'h6D, 8'h6E, 8'h6F}) |=> tx_byte == 8'h00)
      else $error("generic error second byte not zero");
   a_word_ends: assert property (s_sw2_go |=> !tx_valid && !busy)
      else $error("exchange not closed after second byte");
   a_pad_ff: assert property (data_in_valid && data_unassigned |=> data_out_valid && data_out == 8'hFF)
      else $error("unassigned byte not padded");
   a_text_msb: assert property (data_in_valid && data_text7 && !data_unassigned && !data_deleted
      && !data_deleted_last |=> !data_out[7])
      else $error("text byte msb set");
   a_serial_tail: assert property (serial_index > 4'h9 |=> serial_byte == 8'hFF)
      else $error("serial byte beyond file not FF");
endmodule : csw_encoder_sva
bind csw_encoder csw_encoder_sva u_sva (.clk, .rst, .cmd_done, .busy, .class_ok, .ins_known, .tx_valid,
   .tx_ready, .tx_byte, .tx_last, .data_in_valid, .data_unassigned, .data_deleted, .data_deleted_last,
   .data_text7, .data_out_valid, .data_out, .serial_index, .serial_byte);

// >>> test/csw_handset_model.sv
// Purpose: Handset side taking the status bytes
// Assumes: Byte taken when tx_valid and tx_ready high
// Notes: hold stalls the handset
`timescale 1ns/1ns
module csw_handset_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic hold,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_ready,
   output logic [7:0] sw1,
   output logic [7:0] sw2,
   output int words,
   output int order_errs
);
   logic have_sw1;
   initial tx_ready = 1'b0;
   always @(posedge clk) begin
      tx_ready <= !hold;
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         have_sw1 <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         if (tx_last != have_sw1) begin
            order_errs <= order_errs + 1;
         end
         if (tx_last) begin
            sw2 <= tx_byte;
            words <= words + 1;
         end else begin
            sw1 <= tx_byte;
         end
         have_sw1 <= !tx_last;
      end
   end
endmodule : csw_handset_model

// >>> test/csw_encoder_bench.sv
// Purpose: Self-checking bench of the status word encoder
// Assumes: Handset model takes the status bytes
// Notes: Table rows first, awkward cases after
`timescale 1ns/1ns
module csw_encoder_bench;
   import csw_pkg::*;
   typedef struct {
      logic [3:0] ok;
      csw_cmd_t c;
      csw_out_t o;
      logic [1:0] tk;
      logic [7:0] len, e1, e2;
   } csw_row_t;
   logic clk = 1'b0, rst = 1'b1, cmd_done = 1'b0, class_ok = 1'b1, ins_known = 1'b1, p1p2_ok = 1'b1;
   logic p3_ok = 1'b1, card_toolkit = 1'b0, handset_toolkit = 1'b0, seek_type2 = 1'b0, hold = 1'b0;
   logic data_in_valid = 1'b0, data_unassigned = 1'b0, data_deleted = 1'b0, data_deleted_last = 1'b0;
   logic data_text7 = 1'b0, serial_swap = 1'b1, file_optional = 1'b0, item_present = 1'b1, item_mandatory = 1'b1;
   logic [7:0] p3_correct = 8'h00, outcome_len = 8'h00, data_in = 8'h00, deleted_value = 8'hFE;
   logic [79:0] serial_digits = 80'h89441234567890123456;
   logic [4:0] serial_count = 5'h14;
   logic [3:0] serial_index = 4'h0;
   logic [15:0] file_size = 16'h0000;
   csw_cmd_t cmd = CSW_CMD_SELECT;
   csw_out_t outcome = CSW_OUT_OK;
   logic tx_ready, tx_valid, tx_last, busy, data_out_valid, file_ok;
   logic [7:0] tx_byte, data_out, serial_byte, last_sw1, last_sw2, sw1, sw2;
   int words, order_errs, fails, checks_done;
   csw_row_t rows [22] = '{
      '{4'hF, CSW_CMD_SELECT, CSW_OUT_OK, 2'h0, 8'h00, 8'h90, 8'h00},
      '{4'h0, CSW_CMD_RD_REC, CSW_OUT_OUT_OF_RANGE, 2'h0, 8'h00, 8'h6E, 8'h00},
      '{4'h8, CSW_CMD_RD_BIN, CSW_OUT_OK, 2'h0, 8'h00, 8'h6D, 8'h00},
      '{4'hD, CSW_CMD_RD_BIN, CSW_OUT_OK, 2'h0, 8'h00, 8'h6B, 8'h00},
      '{4'hD, CSW_CMD_RD_REC, CSW_OUT_OUT_OF_RANGE, 2'h0, 8'h00, 8'h94, 8'h02},
      '{4'hE, CSW_CMD_UPD_BIN, CSW_OUT_OK, 2'h0, 8'h1C, 8'h67, 8'h1C},
      '{4'hC, CSW_CMD_UPD_BIN, CSW_OUT_OK, 2'h0, 8'h1C, 8'h6B, 8'h00},
      '{4'hF, CSW_CMD_RD_BIN, CSW_OUT_TECH, 2'h0, 8'h00, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_SELECT, CSW_OUT_NO_EF, 2'h0, 8'h00, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_STATUS, CSW_OUT_ACCESS, 2'h0, 8'h00, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_RD_BIN, CSW_OUT_NO_EF, 2'h0, 8'h00, 8'h94, 8'h00},
      '{4'hF, CSW_CMD_SELECT, CSW_OUT_PROACTIVE, 2'h3, 8'h0A, 8'h91, 8'h0A},
      '{4'hF, CSW_CMD_SELECT, CSW_OUT_PROACTIVE, 2'h2, 8'h0A, 8'h90, 8'h00},
      '{4'hF, CSW_CMD_ENVELOPE, CSW_OUT_BUSY, 2'h1, 8'h00, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_ENVELOPE, CSW_OUT_DL_ERROR, 2'h3, 8'h21, 8'h9E, 8'h21},
      '{4'hF, CSW_CMD_SEEK, CSW_OUT_PROACTIVE, 2'h3, 8'h0B, 8'h91, 8'h0B},
      '{4'hF, CSW_CMD_INCREASE, CSW_OUT_PROACTIVE, 2'h3, 8'h0D, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_UPD_BIN, CSW_OUT_RETRY, 2'h0, 8'h35, 8'h92, 8'h05},
      '{4'hF, CSW_CMD_RD_BIN, CSW_OUT_RETRY, 2'h0, 8'h35, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_SLEEP, CSW_OUT_RETRY, 2'h0, 8'h35, 8'h6F, 8'h00},
      '{4'hF, CSW_CMD_SEEK, CSW_OUT_LENGTH, 2'h0, 8'h1A, 8'h9F, 8'h1A},
      '{4'hF, CSW_CMD_VERIFY, CSW_OUT_BLOCKED, 2'h0, 8'h00, 8'h98, 8'h40}
   };
   always #5 clk = ~clk;
   csw_encoder DUT (.clk, .rst, .cmd_done, .class_ok, .ins_known, .cmd, .p1p2_ok, .p3_ok, .p3_correct,
      .outcome, .outcome_len, .card_toolkit, .handset_toolkit, .seek_type2, .tx_ready, .data_in_valid,
      .data_in, .data_unassigned, .data_deleted, .data_deleted_last, .data_text7, .deleted_value,
      .serial_digits, .serial_count, .serial_swap, .serial_index, .file_optional, .file_size, .item_present,
      .item_mandatory, .tx_valid, .tx_byte, .tx_last, .busy, .data_out_valid, .data_out, .serial_byte,
      .file_ok, .last_sw1, .last_sw2);
   csw_handset_model u_handset (.clk, .rst, .hold, .tx_valid, .tx_byte, .tx_last, .tx_ready, .sw1, .sw2,
      .words, .order_errs);
   // ****************
   // Shared tasks
   // ****************
   task automatic give_verdict;
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic run_cmd(input csw_row_t r, input logic st);
      int n;
      n = words;
      @(negedge clk);
      {class_ok, ins_known, p1p2_ok, p3_ok} = r.ok;
      {card_toolkit, handset_toolkit} = r.tk;
      cmd = r.c;
      outcome = r.o;
      outcome_len = r.len;
      p3_correct = r.len;
      hold = st;
      cmd_done = 1'b1;
      @(negedge clk);
      chk("tx_byte", r.e1, tx_byte);
      cmd_done = st;
      class_ok = !st;
      repeat (3) @(negedge clk);
      cmd_done = 1'b0;
      if (st) chk("tx_byte", r.e1, tx_byte);
      hold = 1'b0;
      for (int i = 0; i < 40 && words == n; i++) @(negedge clk);
      if (words == n) begin
         fails++;
         give_verdict();
      end
      chk("sw1", r.e1, sw1);
      chk("sw2", r.e2, sw2);
      chk("last_sw2", r.e2, last_sw2);
      chk("busy", 8'h00, {7'h0, busy});
   endtask : run_cmd
   task automatic dpath(input logic [4:0] f, input logic [7:0] d, input logic [7:0] e);
      @(negedge clk);
      {data_unassigned, data_deleted, data_deleted_last, data_text7, data_in_valid} = f;
      data_in = d;
      @(negedge clk);
      data_in_valid = 1'b0;
      chk("data_out", e, data_out);
   endtask : dpath
   task automatic sck(input logic [4:0] n, input logic sw, input logic [3:0] idx, input logic [7:0] e);
      @(negedge clk);
      serial_count = n;
      serial_swap = sw;
      serial_index = idx;
      @(negedge clk);
      chk("serial_byte", e, serial_byte);
   endtask : sck
   task automatic fchk(input logic [18:0] v, input logic e);
      @(negedge clk);
      {file_optional, file_size, item_present, item_mandatory} = v;
      @(negedge clk);
      chk("file_ok", {7'h0, e}, {7'h0, file_ok});
   endtask : fchk
   task automatic rchk;
      chk("tx_valid", 8'h00, {7'h0, tx_valid});
      chk("last_sw1", 8'h00, last_sw1);
      chk("serial_byte", 8'hFF, serial_byte);
      chk("file_ok", 8'h01, {7'h0, file_ok});
   endtask : rchk
   // ****************
   // Main sequence
   // ****************
   initial begin
      repeat (11) @(negedge clk);
      rchk();
      @(negedge clk);
      rst = 1'b0;
      foreach (rows[i]) run_cmd(rows[i], 1'b0);
      run_cmd(rows[5], 1'b1);
      seek_type2 = 1'b1;
      run_cmd('{4'hF, CSW_CMD_SEEK, CSW_OUT_PROACTIVE, 2'h3, 8'h0C, 8'h90, 8'h00}, 1'b0);
      run_cmd('{4'hF, CSW_CMD_GET_RESP, CSW_OUT_OK, 2'h3, 8'h0C, 8'h91, 8'h0C}, 1'b0);
      seek_type2 = 1'b0;
      dpath(5'b10001, 8'h41, 8'hFF);
      dpath(5'b01101, 8'h12, 8'hFE);
      dpath(5'b01001, 8'h12, 8'hFF);
      dpath(5'b00011, 8'hC1, 8'h41);
      dpath(5'b00001, 8'hA5, 8'hA5);
      sck(5'h14, 1'b1, 4'h0, 8'h98);
      sck(5'h14, 1'b1, 4'h9, 8'h65);
      sck(5'h14, 1'b0, 4'h0, 8'h89);
      sck(5'h12, 1'b1, 4'h8, 8'h43);
      sck(5'h12, 1'b1, 4'h9, 8'hFF);
      sck(5'h14, 1'b1, 4'hA, 8'hFF);
      fchk({1'b1, 16'h0000, 1'b0, 1'b1}, 1'b1);
      fchk({1'b0, 16'h000A, 1'b0, 1'b1}, 1'b0);
      fchk({1'b0, 16'h000A, 1'b1, 1'b1}, 1'b1);
      fchk({1'b1, 16'h000A, 1'b0, 1'b0}, 1'b1);
      @(negedge clk);
      hold = 1'b1;
      cmd_done = 1'b1;
      @(negedge clk);
      cmd_done = 1'b0;
      rst = 1'b1;
      @(negedge clk);
      rchk();
      hold = 1'b0;
      rst = 1'b0;
      run_cmd(rows[0], 1'b0);
      chk("order_errs", 8'h00, order_errs[7:0]);
      give_verdict();
   end
endmodule : csw_encoder_bench
